//--- hdl/desc_pkg.sv
// Constants and types for the segment descriptor decoder
`default_nettype none
package desc_pkg;
  // ===========================================
  // Descriptor field positions (upper word)
  localparam int BASE_HI_MSB = 31;
  localparam int BASE_HI_LSB = 24;
  localparam int GRAN_BIT = 23;
  localparam int SIZE_BIT = 22;
  localparam int SPARE_BIT = 20;
  localparam int LIM_HI_MSB = 19;
  localparam int LIM_HI_LSB = 16;
  localparam int PRESENT_BIT = 15;
  localparam int PRIV_MSB = 14;
  localparam int PRIV_LSB = 13;
  localparam int DTYPE_BIT = 12;
  localparam int TYPE_MSB = 11;
  localparam int TYPE_LSB = 8;
  localparam int BASE_MID_MSB = 7;
  localparam int BASE_MID_LSB = 0;
  // Lower word
  localparam int BASE_LO_MSB = 31;
  localparam int BASE_LO_LSB = 16;
  localparam int LIM_LO_MSB = 15;
  localparam int LIM_LO_LSB = 0;
  // Type bits within the four-bit type
  localparam int T_EXEC = 3;
  localparam int T_CONF = 2;
  localparam int T_RW = 1;
  localparam int T_ACC = 0;
  // ===========================================
  // Sizes
  localparam int DESC_BYTES = 8;
  localparam int GRAN_SHIFT = 12;
  localparam int VEC_ENTRIES = 256;
  localparam int PM_ENTRY_SHIFT = 3;
  localparam int RM_ENTRY_SHIFT = 2;
  localparam logic [11:0] GRAN_FILL = 12'hfff;
  localparam logic [31:0] PTR_BASE_RST = 32'h0000_0000;
  localparam logic [15:0] PTR_LIMIT_RST = 16'h03ff;
  // ===========================================
  // System type codes
  localparam logic [3:0] SYS_CALL16 = 4'h4;
  localparam logic [3:0] SYS_TASK = 4'h5;
  localparam logic [3:0] SYS_INT16 = 4'h6;
  localparam logic [3:0] SYS_TRAP16 = 4'h7;
  typedef enum logic [2:0] {GATE_NONE, GATE_CALL16, GATE_TASK, GATE_INT16, GATE_TRAP16} gate_e;
  typedef enum {PTR_IDLE, PTR_LOAD_HI, PTR_STORE_HI} ptr_state_e;
endpackage
`default_nettype wire

//--- hdl/desc_field_decode.sv
// Combinational field extraction of one eight-byte descriptor
`default_nettype none
module desc_field_decode (
  input wire logic [31:0] lower_word,
  input wire logic [31:0] upper_word,
  output logic [31:0] base,
  output logic [31:0] scaled_limit,
  output logic present,
  output logic [1:0] privilege,
  output logic code_or_data,
  output logic [3:0] seg_type,
  output logic default_32,
  output logic gran_4k
);
  logic [19:0] raw_limit;
  always_comb
  begin
    base = {upper_word[desc_pkg::BASE_HI_MSB:desc_pkg::BASE_HI_LSB],
            upper_word[desc_pkg::BASE_MID_MSB:desc_pkg::BASE_MID_LSB],
            lower_word[desc_pkg::BASE_LO_MSB:desc_pkg::BASE_LO_LSB]};
    raw_limit = {upper_word[desc_pkg::LIM_HI_MSB:desc_pkg::LIM_HI_LSB],
                 lower_word[desc_pkg::LIM_LO_MSB:desc_pkg::LIM_LO_LSB]};
    gran_4k = upper_word[desc_pkg::GRAN_BIT];
    // Page units fill the low twelve bits so the last page is whole
    if (gran_4k)
    begin
      scaled_limit = {raw_limit, desc_pkg::GRAN_FILL};
    end
    else
    begin
      scaled_limit = {12'h000, raw_limit};
    end
    default_32 = upper_word[desc_pkg::SIZE_BIT];
    present = upper_word[desc_pkg::PRESENT_BIT];
    privilege = upper_word[desc_pkg::PRIV_MSB:desc_pkg::PRIV_LSB];
    code_or_data = upper_word[desc_pkg::DTYPE_BIT];
    seg_type = upper_word[desc_pkg::TYPE_MSB:desc_pkg::TYPE_LSB];
  end
endmodule
`default_nettype wire

//--- hdl/vector_table_pointer.sv
// Interrupt vector table pointer register with load and store
`default_nettype none
module vector_table_pointer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic load_vector_table_pointer,
  input wire logic store_vector_table_pointer,
  input wire logic [31:0] mem_word_in,
  output logic [31:0] ptr_base,
  output logic [15:0] ptr_limit,
  output logic [31:0] mem_word_out,
  output logic mem_word_valid,
  output logic busy
);
  desc_pkg::ptr_state_e state_q, state_d;
  logic [31:0] base_q, base_d;
  logic [15:0] limit_q, limit_d;
  logic [31:0] out_q, out_d;
  logic valid_q, valid_d;
  logic busy_q, busy_d;
  // Load image: word 0 = limit in low half, base low half in high; word 1 = base high
  always_comb
  begin
    state_d = state_q;
    base_d = base_q;
    limit_d = limit_q;
    out_d = out_q;
    valid_d = 1'b0;
    case (state_q)
      desc_pkg::PTR_IDLE:
      begin
        if (load_vector_table_pointer)
        begin
          // Linear address already resolved by the pipeline, no segment applied
          limit_d = mem_word_in[15:0];
          base_d = {base_q[31:16], mem_word_in[31:16]};
          state_d = desc_pkg::PTR_LOAD_HI;
        end
        else if (store_vector_table_pointer)
        begin
          out_d = {base_q[15:0], limit_q};
          valid_d = 1'b1;
          state_d = desc_pkg::PTR_STORE_HI;
        end
      end
      desc_pkg::PTR_LOAD_HI:
      begin
        base_d = {mem_word_in[15:0], base_q[15:0]};
        state_d = desc_pkg::PTR_IDLE;
      end
      desc_pkg::PTR_STORE_HI:
      begin
        out_d = {16'h0000, base_q[31:16]};
        valid_d = 1'b1;
        state_d = desc_pkg::PTR_IDLE;
      end
      default:
      begin
        state_d = desc_pkg::PTR_IDLE;
      end
    endcase
    // Registered so the top level sees busy from a flop
    busy_d = (state_d != desc_pkg::PTR_IDLE);
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= desc_pkg::PTR_IDLE;
      base_q <= desc_pkg::PTR_BASE_RST;
      limit_q <= desc_pkg::PTR_LIMIT_RST;
      out_q <= 32'h0000_0000;
      valid_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      base_q <= base_d;
      limit_q <= limit_d;
      out_q <= out_d;
      valid_q <= valid_d;
      busy_q <= busy_d;
    end
  end
  assign ptr_base = base_q;
  assign ptr_limit = limit_q;
  assign mem_word_out = out_q;
  assign mem_word_valid = valid_q;
  assign busy = busy_q;
endmodule
`default_nettype wire

//--- hdl/segment_descriptor_decoder.sv
// Segment descriptor decode, limit check and vector table lookup
`default_nettype none
module segment_descriptor_decoder (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic desc_valid,
  input wire logic [31:0] desc_lower,
  input wire logic [31:0] desc_upper,
  input wire logic seg_load,
  input wire logic access_valid,
  input wire logic [31:0] access_offset,
  input wire logic vec_valid,
  input wire logic [7:0] vec_num,
  input wire logic real_mode,
  input wire logic load_vector_table_pointer,
  input wire logic store_vector_table_pointer,
  input wire logic [31:0] mem_word_in,
  output logic [31:0] seg_base,
  output logic [31:0] seg_limit,
  output logic seg_present,
  output logic [1:0] descriptor_privilege,
  output logic most_privileged,
  output logic code_or_data,
  output logic system_seg,
  output logic executable,
  output logic accessed,
  output logic conforming,
  output logic expand_down,
  output logic read_enable,
  output logic write_enable,
  output logic operand_32,
  output logic stack_32,
  output logic [2:0] gate_kind,
  output logic not_present_fault,
  output logic protection_fault,
  output logic [31:0] linear_addr,
  output logic linear_valid,
  output logic [31:0] vec_entry_addr,
  output logic vec_entry_valid,
  output logic vec_limit_fault,
  output logic [31:0] mem_word_out,
  output logic mem_word_valid,
  output logic ptr_busy
);
  // ===========================================
  // Field decode of the incoming record
  logic [31:0] f_base, f_limit;
  logic f_present, f_cd, f_d32;
  logic [1:0] f_priv;
  logic [3:0] f_type;
  desc_field_decode u_fields (
    .lower_word(desc_lower),
    .upper_word(desc_upper),
    .base(f_base),
    .scaled_limit(f_limit),
    .present(f_present),
    .privilege(f_priv),
    .code_or_data(f_cd),
    .seg_type(f_type),
    .default_32(f_d32),
    .gran_4k()
  );
  // ===========================================
  // Vector table pointer register
  logic [31:0] ptr_base;
  logic [15:0] ptr_limit;
  logic ptr_out_valid, ptr_busy_w;
  logic [31:0] ptr_out;
  vector_table_pointer u_ptr (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .load_vector_table_pointer(load_vector_table_pointer),
    .store_vector_table_pointer(store_vector_table_pointer),
    .mem_word_in(mem_word_in),
    .ptr_base(ptr_base),
    .ptr_limit(ptr_limit),
    .mem_word_out(ptr_out),
    .mem_word_valid(ptr_out_valid),
    .busy(ptr_busy_w)
  );
  function automatic desc_pkg::gate_e gate_of(input logic cd, input logic [3:0] t);
    gate_of = desc_pkg::GATE_NONE;
    if (!cd)
    begin
      case (t)
        desc_pkg::SYS_CALL16: gate_of = desc_pkg::GATE_CALL16;
        desc_pkg::SYS_TASK: gate_of = desc_pkg::GATE_TASK;
        desc_pkg::SYS_INT16: gate_of = desc_pkg::GATE_INT16;
        desc_pkg::SYS_TRAP16: gate_of = desc_pkg::GATE_TRAP16;
        default: gate_of = desc_pkg::GATE_NONE;
      endcase
    end
  endfunction
  // ===========================================
  // Cached descriptor state
  logic [31:0] base_q, base_d, limit_q, limit_d;
  logic pres_q, pres_d, cd_q, cd_d, valid_q, valid_d;
  logic [1:0] priv_q, priv_d;
  logic [2:0] gate_q, gate_d;
  logic np_q, np_d;
  // Attributes decoded ahead of the flops so no output is a gate
  logic top_q, top_d, sys_q, sys_d, exe_q, exe_d, acc_q, acc_d, conf_q, conf_d;
  logic expd_q, expd_d, rden_q, rden_d, wren_q, wren_d, op32_q, op32_d, st32_q, st32_d;
  always_comb
  begin
    base_d = base_q;
    limit_d = limit_q;
    pres_d = pres_q;
    cd_d = cd_q;
    priv_d = priv_q;
    gate_d = gate_q;
    top_d = top_q;
    sys_d = sys_q;
    exe_d = exe_q;
    acc_d = acc_q;
    conf_d = conf_q;
    expd_d = expd_q;
    rden_d = rden_q;
    wren_d = wren_q;
    op32_d = op32_q;
    st32_d = st32_q;
    valid_d = valid_q;
    np_d = 1'b0;
    // Whole eight-byte record latched at once; spare bit 20 is never looked at
    if (desc_valid)
    begin
      valid_d = 1'b1;
      pres_d = f_present;
      cd_d = f_cd;
      priv_d = f_priv;
      top_d = (f_priv == 2'b00);
      sys_d = !f_cd;
      exe_d = f_type[desc_pkg::T_EXEC];
      acc_d = f_type[desc_pkg::T_ACC];
      conf_d = f_cd & f_type[desc_pkg::T_CONF];
      expd_d = !f_cd & f_type[desc_pkg::T_CONF];
      rden_d = f_cd & f_type[desc_pkg::T_RW];
      wren_d = !f_cd & f_type[desc_pkg::T_RW];
      op32_d = f_cd & f_type[desc_pkg::T_EXEC] & f_d32;
      st32_d = f_cd & !f_type[desc_pkg::T_EXEC] & f_d32;
      gate_d = 3'(gate_of(f_cd, f_type));
      // Absent segment: base and limit cleared to zero
      if (f_present)
      begin
        base_d = f_base;
        limit_d = f_limit;
      end
      else
      begin
        base_d = 32'h0000_0000;
        limit_d = 32'h0000_0000;
      end
      np_d = seg_load && !f_present;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_q <= 32'h0000_0000;
      limit_q <= 32'h0000_0000;
      pres_q <= 1'b0;
      cd_q <= 1'b0;
      priv_q <= 2'b00;
      top_q <= 1'b0;
      sys_q <= 1'b0;
      exe_q <= 1'b0;
      acc_q <= 1'b0;
      conf_q <= 1'b0;
      expd_q <= 1'b0;
      rden_q <= 1'b0;
      wren_q <= 1'b0;
      op32_q <= 1'b0;
      st32_q <= 1'b0;
      gate_q <= 3'(desc_pkg::GATE_NONE);
      valid_q <= 1'b0;
      np_q <= 1'b0;
    end
    else
    begin
      base_q <= base_d;
      limit_q <= limit_d;
      pres_q <= pres_d;
      cd_q <= cd_d;
      priv_q <= priv_d;
      top_q <= top_d;
      sys_q <= sys_d;
      exe_q <= exe_d;
      acc_q <= acc_d;
      conf_q <= conf_d;
      expd_q <= expd_d;
      rden_q <= rden_d;
      wren_q <= wren_d;
      op32_q <= op32_d;
      st32_q <= st32_d;
      gate_q <= gate_d;
      valid_q <= valid_d;
      np_q <= np_d;
    end
  end
  // ===========================================
  // Offset check and linear address
  logic [31:0] lin_q, lin_d;
  logic lin_v_q, lin_v_d, pf_q, pf_d;
  always_comb
  begin
    lin_d = lin_q;
    lin_v_d = 1'b0;
    pf_d = 1'b0;
    if (access_valid)
    begin
      // No usable segment or offset past limit both refuse the access
      if (!valid_q || !pres_q || access_offset > limit_q)
      begin
        pf_d = 1'b1;
      end
      else
      begin
        lin_d = base_q + access_offset;
        lin_v_d = 1'b1;
      end
    end
  end
  // ===========================================
  // Vector table entry location
  logic [31:0] vaddr_q, vaddr_d, voff;
  logic [15:0] vlast;
  logic vv_q, vv_d, vf_q, vf_d;
  always_comb
  begin
    vaddr_d = vaddr_q;
    vv_d = 1'b0;
    vf_d = 1'b0;
    if (real_mode)
    begin
      voff = {22'h000000, vec_num, 2'b00};
    end
    else
    begin
      voff = {21'h000000, vec_num, 3'b000};
    end
    vlast = voff[15:0] + (real_mode ? 16'h0003 : 16'h0007);
    if (vec_valid)
    begin
      // Entry must lie wholly inside the table limit in the pointer register, last byte up to the limit
      if (vlast > ptr_limit)
      begin
        vf_d = 1'b1;
      end
      else
      begin
        vaddr_d = ptr_base + voff;
        vv_d = 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lin_q <= 32'h0000_0000;
      lin_v_q <= 1'b0;
      pf_q <= 1'b0;
      vaddr_q <= 32'h0000_0000;
      vv_q <= 1'b0;
      vf_q <= 1'b0;
    end
    else
    begin
      lin_q <= lin_d;
      lin_v_q <= lin_v_d;
      pf_q <= pf_d;
      vaddr_q <= vaddr_d;
      vv_q <= vv_d;
      vf_q <= vf_d;
    end
  end
  // ===========================================
  // Outputs, each straight from a flop
  assign seg_base = base_q;
  assign seg_limit = limit_q;
  assign seg_present = pres_q;
  assign descriptor_privilege = priv_q;
  assign most_privileged = top_q;
  assign code_or_data = cd_q;
  assign system_seg = sys_q;
  assign executable = exe_q;
  assign accessed = acc_q;
  assign conforming = conf_q;
  assign expand_down = expd_q;
  assign read_enable = rden_q;
  assign write_enable = wren_q;
  assign operand_32 = op32_q;
  assign stack_32 = st32_q;
  assign gate_kind = gate_q;
  assign not_present_fault = np_q;
  assign protection_fault = pf_q;
  assign linear_addr = lin_q;
  assign linear_valid = lin_v_q;
  assign vec_entry_addr = vaddr_q;
  assign vec_entry_valid = vv_q;
  assign vec_limit_fault = vf_q;
  assign mem_word_out = ptr_out;
  assign mem_word_valid = ptr_out_valid;
  assign ptr_busy = ptr_busy_w;
endmodule
`default_nettype wire

//--- tb/desc_props.sv
// Port level checks on the segment descriptor decoder
`default_nettype none
module desc_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic desc_valid,
  input wire logic [31:0] desc_lower,
  input wire logic [31:0] desc_upper,
  input wire logic seg_load,
  input wire logic access_valid,
  input wire logic vec_valid,
  input wire logic load_vector_table_pointer,
  input wire logic store_vector_table_pointer,
  input wire logic [31:0] seg_base,
  input wire logic [31:0] seg_limit,
  input wire logic [1:0] descriptor_privilege,
  input wire logic most_privileged,
  input wire logic code_or_data,
  input wire logic system_seg,
  input wire logic not_present_fault,
  input wire logic protection_fault,
  input wire logic linear_valid,
  input wire logic vec_entry_valid,
  input wire logic vec_limit_fault,
  input wire logic mem_word_valid,
  input wire logic ptr_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Sequences
  sequence np_load;
    desc_valid && seg_load && !desc_upper[15];
  endsequence
  sequence two_words;
    mem_word_valid ##1 mem_word_valid;
  endsequence
  // ==========================================
  // Assertions
  not_present_a: assert property (np_load |=> not_present_fault)
    else $error("not present fault does not follow its cause");
  np_cause_a: assert property (not_present_fault |->
    $past(desc_valid) && $past(seg_load) && !$past(desc_upper[15]))
    else $error("not present fault without a cause");
  base_build_a: assert property (desc_valid && desc_upper[15] |=> seg_base ==
    {$past(desc_upper[31:24]), $past(desc_upper[7:0]), $past(desc_lower[31:16])})
    else $error("segment base assembled wrongly");
  limit_scale_a: assert property (desc_valid && desc_upper[15] |=> seg_limit ==
    ($past(desc_upper[23]) ? {$past(desc_upper[19:16]), $past(desc_lower[15:0]), 12'hfff}
    : {12'h000, $past(desc_upper[19:16]), $past(desc_lower[15:0])}))
    else $error("segment limit scaled wrongly");
  priv_decode_a: assert property (desc_valid |=> descriptor_privilege ==
    $past(desc_upper[14:13]) && most_privileged == ($past(desc_upper[14:13]) == 2'b00))
    else $error("privilege decode wrong");
  class_decode_a: assert property (desc_valid |=> code_or_data == $past(desc_upper[12])
    && system_seg == !code_or_data)
    else $error("descriptor class wrong");
  access_answer_a: assert property (access_valid |=> linear_valid ^ protection_fault)
    else $error("access gave no single answer");
  vec_answer_a: assert property (vec_valid |=> vec_entry_valid ^ vec_limit_fault)
    else $error("vector lookup gave no single answer");
  store_words_a: assert property (store_vector_table_pointer &&
    !load_vector_table_pointer && !ptr_busy |=> two_words ##1 !mem_word_valid)
    else $error("pointer store did not give two words");
endmodule
`default_nettype wire

//--- tb/desc_table_mem.sv
// Memory image of descriptor table entries and the table pointer image
`default_nettype none
module desc_table_mem (
  input wire logic rd,
  input wire logic [2:0] idx,
  output logic [31:0] lower,
  output logic [31:0] upper
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] lo_m;
  logic [31:0] up_m;
  always_comb
  begin
    case (idx)
      3'h0: {up_m, lo_m} = {32'h12d09a34, 32'h56780012};
      3'h1: {up_m, lo_m} = {32'h004ff6ab, 32'hcdef0100};
      3'h2: {up_m, lo_m} = {32'h00407600, 32'h1234ffff};
      3'h7: {up_m, lo_m} = {32'h00000010, 32'h000007ff};
      default: {up_m, lo_m} = {16'h0000, 4'h8, 1'b0, idx + 3'h1, 8'h00, 32'h0000ffff};
    endcase
  end
  // Whole eight-byte record per read; a released bus shows inverted data
  assign lower = rd ? lo_m : ~lo_m;
  assign upper = rd ? up_m : ~up_m;
endmodule
`default_nettype wire

//--- tb/segment_descriptor_decoder_tb_top.sv
// Directed testbench for the segment descriptor decoder
`default_nettype none
module segment_descriptor_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, desc_valid, seg_load, access_valid, vec_valid, real_mode;
  logic ld_ptr, st_ptr, rd, ptr_hi, seg_present, most_privileged, system_seg, executable;
  logic conforming, expand_down, read_enable, write_enable, operand_32, stack_32;
  logic not_present_fault, protection_fault, linear_valid, vec_entry_valid;
  logic vec_limit_fault, mem_word_valid, ptr_busy, accessed;
  logic [31:0] desc_lower, desc_upper, access_offset, mem_word_in, seg_base, seg_limit;
  logic [31:0] linear_addr, vec_entry_addr, mem_word_out;
  logic [7:0] vec_num;
  logic [2:0] idx, gate_kind;
  logic [1:0] descriptor_privilege;
  int mismatches = 0;
  int samples_checked = 0;
  assign mem_word_in = ptr_hi ? desc_upper : desc_lower;
  desc_table_mem mem (.rd(rd), .idx(idx), .lower(desc_lower), .upper(desc_upper));
  segment_descriptor_decoder dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .desc_valid(desc_valid), .desc_lower(desc_lower), .desc_upper(desc_upper),
    .seg_load(seg_load), .access_valid(access_valid), .access_offset(access_offset),
    .vec_valid(vec_valid), .vec_num(vec_num), .real_mode(real_mode),
    .load_vector_table_pointer(ld_ptr), .store_vector_table_pointer(st_ptr),
    .mem_word_in(mem_word_in), .seg_base(seg_base), .seg_limit(seg_limit),
    .seg_present(seg_present), .descriptor_privilege(descriptor_privilege),
    .most_privileged(most_privileged), .code_or_data(), .system_seg(system_seg),
    .executable(executable), .accessed(accessed), .conforming(conforming),
    .expand_down(expand_down), .read_enable(read_enable), .write_enable(write_enable),
    .operand_32(operand_32), .stack_32(stack_32), .gate_kind(gate_kind),
    .not_present_fault(not_present_fault), .protection_fault(protection_fault),
    .linear_addr(linear_addr), .linear_valid(linear_valid),
    .vec_entry_addr(vec_entry_addr), .vec_entry_valid(vec_entry_valid),
    .vec_limit_fault(vec_limit_fault), .mem_word_out(mem_word_out),
    .mem_word_valid(mem_word_valid), .ptr_busy(ptr_busy));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chkb(input string what, input logic e, input logic g);
    chk(what, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wait_idle();
    int n = 0;
    while (ptr_busy !== 1'b0 && n < 8)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (ptr_busy !== 1'b0)
    begin
      chkb("ptr_busy", 1'b0, ptr_busy);
      results();
    end
  endtask
  task automatic give_desc(input logic [2:0] i, input logic ld);
    @(negedge ref_clk);
    rd = 1'b1;
    idx = i;
    seg_load = ld;
    desc_valid = 1'b1;
    @(negedge ref_clk);
    desc_valid = 1'b0;
    seg_load = 1'b0;
    rd = 1'b0;
  endtask
  task automatic access(input logic [31:0] off, input logic [31:0] ea, input logic f);
    @(negedge ref_clk);
    access_valid = 1'b1;
    access_offset = off;
    @(negedge ref_clk);
    access_valid = 1'b0;
    chkb("protection_fault", f, protection_fault);
    chkb("linear_valid", !f, linear_valid);
    if (!f) chk("linear_addr", ea, linear_addr);
  endtask
  task automatic vec(input logic [7:0] n, input logic rm, input logic [31:0] ea, input logic f);
    @(negedge ref_clk);
    vec_valid = 1'b1;
    vec_num = n;
    real_mode = rm;
    @(negedge ref_clk);
    vec_valid = 1'b0;
    chkb("vec_limit_fault", f, vec_limit_fault);
    chkb("vec_entry_valid", !f, vec_entry_valid);
    if (!f) chk("vec_entry_addr", ea, vec_entry_addr);
  endtask
  task automatic store_ptr(input logic [31:0] w0, input logic [31:0] w1);
    @(negedge ref_clk);
    st_ptr = 1'b1;
    @(negedge ref_clk);
    st_ptr = 1'b0;
    chkb("mem_word_valid", 1'b1, mem_word_valid);
    chk("word0", w0, mem_word_out);
    @(negedge ref_clk);
    chk("word1", w1, mem_word_out);
    wait_idle();
  endtask
  task automatic load_ptr();
    @(negedge ref_clk);
    rd = 1'b1;
    idx = 3'h7;
    ptr_hi = 1'b0;
    ld_ptr = 1'b1;
    @(negedge ref_clk);
    ld_ptr = 1'b0;
    ptr_hi = 1'b1;
    chkb("ptr_busy", 1'b1, ptr_busy);
    @(negedge ref_clk);
    rd = 1'b0;
    ptr_hi = 1'b0;
    wait_idle();
  endtask
  initial
  begin
    {rst_n, desc_valid, seg_load, access_valid, vec_valid, real_mode} = 6'h00;
    {ld_ptr, st_ptr, rd, ptr_hi} = 4'h0;
    {access_offset, vec_num, idx} = 43'h0;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    // ==========================================
    // Vector table pointer
    vec(8'd127, 1'b0, 32'h000003f8, 1'b0);
    vec(8'd128, 1'b0, 32'h0, 1'b1);
    store_ptr(32'h000003ff, 32'h00000000);
    load_ptr();
    store_ptr(32'h000007ff, 32'h00000010);
    vec(8'd255, 1'b0, 32'h001007f8, 1'b0);
    vec(8'd255, 1'b1, 32'h001003fc, 1'b0);
    // ==========================================
    // Code segment, page granular, spare bit set
    give_desc(3'h0, 1'b1);
    chk("seg_base", 32'h12345678, seg_base);
    chk("seg_limit", 32'h00012fff, seg_limit);
    chkb("operand_32", 1'b1, operand_32);
    chkb("executable", 1'b1, executable);
    chkb("read_enable", 1'b1, read_enable);
    chkb("most_privileged", 1'b1, most_privileged);
    chkb("accessed", 1'b0, accessed);
    chkb("not_present_fault", 1'b0, not_present_fault);
    access(32'h00012fff, 32'h12358677, 1'b0);
    access(32'h00013000, 32'h0, 1'b1);
    // Stack data segment, byte granular
    give_desc(3'h1, 1'b1);
    chk("seg_limit", 32'h000f0100, seg_limit);
    chk("privilege", 32'h3, {30'h0, descriptor_privilege});
    chkb("stack_32", 1'b1, stack_32);
    chkb("operand_32", 1'b0, operand_32);
    chkb("conforming", 1'b1, conforming);
    chkb("expand_down", 1'b0, expand_down);
    // Not present, with and without a segment load
    give_desc(3'h2, 1'b1);
    chkb("not_present_fault", 1'b1, not_present_fault);
    chkb("seg_present", 1'b0, seg_present);
    chk("seg_limit", 32'h0, seg_limit);
    access(32'h0, 32'h0, 1'b1);
    give_desc(3'h2, 1'b0);
    chkb("not_present_fault", 1'b0, not_present_fault);
    // System gate codes
    for (int k = 3; k < 7; k++)
    begin
      give_desc(k[2:0], 1'b0);
      chk("gate_kind", k - 2, {29'h0, gate_kind});
      chkb("system_seg", 1'b1, system_seg);
      chkb("write_enable", k > 4, write_enable);
      chkb("expand_down", 1'b1, expand_down);
      chkb("conforming", 1'b0, conforming);
      chkb("accessed", k % 2 == 0, accessed);
    end
    results();
  end
endmodule
bind segment_descriptor_decoder desc_props props (.ref_clk(ref_clk), .rst_n(rst_n),
  .desc_valid(desc_valid), .desc_lower(desc_lower), .desc_upper(desc_upper),
  .seg_load(seg_load), .access_valid(access_valid), .vec_valid(vec_valid),
  .load_vector_table_pointer(load_vector_table_pointer),
  .store_vector_table_pointer(store_vector_table_pointer), .seg_base(seg_base),
  .seg_limit(seg_limit), .descriptor_privilege(descriptor_privilege),
  .most_privileged(most_privileged), .code_or_data(code_or_data),
  .system_seg(system_seg), .not_present_fault(not_present_fault),
  .protection_fault(protection_fault), .linear_valid(linear_valid),
  .vec_entry_valid(vec_entry_valid), .vec_limit_fault(vec_limit_fault),
  .mem_word_valid(mem_word_valid), .ptr_busy(ptr_busy));
`default_nettype wire
